// [hw/spi_ss_pkg.sv]
// Constants and carrier types of the slave-select control block
`default_nettype none
package spi_ss_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SCK_HALF_NS   = 40;
	localparam int unsigned SCK_HALF_CYC  =
		(SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DIV_W         = 3;
	localparam int unsigned DATA_W        = 8;
	localparam logic [DIV_W-1:0] DIV_RST  = 3'h0;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
	localparam logic [2:0] CNT_RST        = 3'h0;
	localparam logic [2:0] LAST_BIT       = 3'h7;
	localparam logic [7:0] DATA_RST       = 8'h00;
	localparam logic [1:0] RXQ_EMPTY      = 2'h0;
	localparam logic [1:0] RXQ_FULL       = 2'h2;
	localparam logic [3:0] PINS_IN        = 4'hF;
	localparam logic [3:0] PINS_LOW       = 4'h0;

	typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH} mstate_e;

	typedef struct packed {
		logic ss;
		logic sck;
		logic mosi;
		logic miso;
	} pin_bus_s;

	typedef struct packed {
		pin_bus_s            s1;
		pin_bus_s            s2;
		logic                sck_d;
		logic                master;
		logic                flag;
		mstate_e             mst;
		logic [DIV_W-1:0]    div;
		logic [2:0]          cnt;
		logic                mbit;
		logic [DATA_W-1:0]   shift;
		logic [DATA_W-1:0]   tx_hold;
		logic [1:0][DATA_W-1:0] rxq;
		logic                rx_wp;
		logic                rx_rp;
		logic [1:0]          rx_cnt;
		pin_bus_s            val;
		pin_bus_s            oe_n;
	} state_s;
endpackage : spi_ss_pkg
`default_nettype wire

// [hw/spi_ss_ctrl.sv]
// Slave-select control with a small shifter and receive buffer
//
// Operation
// - A slave seeing select high clears its bit counter and drops partial bits at once.
// - As slave the select pin is always an input.
// - Slave with select low is active and drives MISO only if the user asks; rest are inputs.
// - Slave with select high keeps all pins as inputs and receives nothing.
// - As master the select pin direction is the user's own choice.
// - Master with select as output treats it as a plain output with no effect on the unit.
// - Select driven low on a master whose select is an input clears the master bit.
// - That forced switch returns MOSI and SCK to inputs.
// - The forced switch sets the done flag; an interrupt needs both enables.
// - After the forced switch only a software write brings master mode back.
// - A slave with select high accepts new data but shifts nothing out.
// - The done flag is set after each full byte in both modes.
`default_nettype none
module spi_ss_ctrl (
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire spi_ss_pkg::pin_bus_s        pin_in,
	output var  spi_ss_pkg::pin_bus_s        pin_out,
	output var  spi_ss_pkg::pin_bus_s        pin_oe_n,
	input  wire spi_ss_pkg::pin_bus_s        pin_dir,
	input  wire logic                        ss_level,
	input  wire logic                        serial_unit_enable,
	input  wire logic                        master_wr,
	input  wire logic                        master_wdata,
	output logic                             master_select_bit,
	output logic                             transfer_done_flag,
	input  wire logic                        flag_clr,
	input  wire logic                        transfer_irq_enable,
	input  wire logic                        global_irq_enable,
	output logic                             irq,
	input  wire logic                        tx_valid,
	input  wire logic [spi_ss_pkg::DATA_W-1:0] tx_data,
	output logic                             tx_ready,
	output logic                             rx_valid,
	output logic [spi_ss_pkg::DATA_W-1:0]    rx_data,
	input  wire logic                        rx_ready
);
	spi_ss_pkg::state_s                st;
	spi_ss_pkg::state_s                next_st;
	logic                              loss;
	logic                              active;
	logic                              rise;
	logic                              rx_full;
	logic                              tx_take;
	logic                              pop;
	logic                              done;
	logic                              push;
	logic [spi_ss_pkg::DATA_W-1:0]     push_data;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Only the second sync stage is ever read
	assign loss    = serial_unit_enable & st.master & ~pin_dir.ss & ~st.s2.ss;
	assign active  = serial_unit_enable & ~st.master & ~st.s2.ss;
	assign rise    = st.s2.sck & ~st.sck_d;
	assign rx_full = st.rx_cnt == spi_ss_pkg::RXQ_FULL;
	// Master stalls its next byte while the buffer is full
	assign tx_ready = ~st.master | ((st.mst == spi_ss_pkg::M_IDLE) & ~rx_full);
	assign tx_take  = tx_valid & tx_ready;
	assign rx_valid = st.rx_cnt != spi_ss_pkg::RXQ_EMPTY;
	assign rx_data  = st.rxq[st.rx_rp];
	assign pop      = rx_valid & rx_ready;

	assign master_select_bit  = st.master;
	assign transfer_done_flag = st.flag;
	assign irq      = st.flag & transfer_irq_enable & global_irq_enable;
	assign pin_out  = st.val;
	assign pin_oe_n = st.oe_n;

	always_comb begin
		next_st   = st;
		done      = 1'b0;
		push_data = st.shift;
		push      = 1'b0;
		next_st.s1    = pin_in;
		next_st.s2    = st.s1;
		next_st.sck_d = st.s2.sck;
		if (st.master & serial_unit_enable) begin
			case (st.mst)
				spi_ss_pkg::M_IDLE: begin
					if (tx_take) begin
						next_st.shift = tx_data;
						next_st.cnt   = spi_ss_pkg::CNT_RST;
						next_st.div   = spi_ss_pkg::DIV_RST;
						next_st.mst   = spi_ss_pkg::M_LOW;
					end
				end
				spi_ss_pkg::M_LOW: begin
					next_st.div = st.div + 3'h1;
					if (st.div == spi_ss_pkg::DIV_LAST) begin
						next_st.div  = spi_ss_pkg::DIV_RST;
						next_st.mst  = spi_ss_pkg::M_HIGH;
						next_st.mbit = st.s2.miso;
					end
				end
				spi_ss_pkg::M_HIGH: begin
					next_st.div = st.div + 3'h1;
					if (st.div == spi_ss_pkg::DIV_LAST) begin
						// Shift on the falling edge so MOSI is stable at the rise
						next_st.div   = spi_ss_pkg::DIV_RST;
						push_data     = {st.shift[6:0], st.mbit};
						next_st.shift = push_data;
						if (st.cnt == spi_ss_pkg::LAST_BIT) begin
							done        = 1'b1;
							next_st.mst = spi_ss_pkg::M_IDLE;
						end else begin
							next_st.cnt = st.cnt + 3'h1;
							next_st.mst = spi_ss_pkg::M_LOW;
						end
					end
				end
				default: next_st.mst = spi_ss_pkg::M_IDLE;
			endcase
		end else begin
			next_st.mst = spi_ss_pkg::M_IDLE;
			if (tx_take & ~st.master) begin
				next_st.tx_hold = tx_data;
			end
			if (!active) begin
				// Idle slave: counter cleared, partial bits dropped
				next_st.cnt   = spi_ss_pkg::CNT_RST;
				next_st.shift = next_st.tx_hold;
			end else if (rise) begin
				push_data     = {st.shift[6:0], st.s2.mosi};
				next_st.shift = push_data;
				if (st.cnt == spi_ss_pkg::LAST_BIT) begin
					done          = 1'b1;
					next_st.cnt   = spi_ss_pkg::CNT_RST;
					next_st.shift = st.tx_hold;
				end else begin
					next_st.cnt = st.cnt + 3'h1;
				end
			end
		end
		if (loss) begin
			next_st.master = 1'b0;
			next_st.mst    = spi_ss_pkg::M_IDLE;
			next_st.cnt    = spi_ss_pkg::CNT_RST;
		end
		// Only software can raise the master bit again
		if (master_wr) begin
			next_st.master = master_wdata;
		end
		// A new event wins over a clear in the same cycle
		next_st.flag = done | loss | (st.flag & ~flag_clr);
		// Overrun: a byte finished while both entries are full is dropped
		push = done & ~rx_full;
		if (push) begin
			next_st.rxq[st.rx_wp] = push_data;
			next_st.rx_wp         = ~st.rx_wp;
		end
		if (pop) begin
			next_st.rx_rp = ~st.rx_rp;
		end
		case ({push, pop})
			2'b10:   next_st.rx_cnt = st.rx_cnt + 2'h1;
			2'b01:   next_st.rx_cnt = st.rx_cnt - 2'h1;
			default: next_st.rx_cnt = st.rx_cnt;
		endcase
		// Pin drive follows the next mode so a lost master lets go at once
		next_st.val.ss   = ss_level;
		next_st.val.sck  = 1'b0;
		next_st.val.mosi = 1'b0;
		next_st.val.miso = 1'b0;
		next_st.oe_n     = ~pin_dir;
		if (serial_unit_enable & next_st.master) begin
			next_st.oe_n.ss   = ~pin_dir.ss;
			next_st.val.sck   = next_st.mst == spi_ss_pkg::M_HIGH;
			next_st.val.mosi  = next_st.shift[7];
			next_st.oe_n.miso = 1'b1;
		end else if (serial_unit_enable) begin
			next_st.oe_n      = spi_ss_pkg::PINS_IN;
			next_st.val.miso  = next_st.shift[7];
			next_st.oe_n.miso = ~(active & ~loss & pin_dir.miso);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st         <= '0;
			st.s1      <= spi_ss_pkg::PINS_IN;
			st.s2      <= spi_ss_pkg::PINS_IN;
			// Same level as the synchroniser reset, so no false rise after reset
			st.sck_d   <= 1'b1;
			st.mst     <= spi_ss_pkg::M_IDLE;
			st.div     <= spi_ss_pkg::DIV_RST;
			st.cnt     <= spi_ss_pkg::CNT_RST;
			st.shift   <= spi_ss_pkg::DATA_RST;
			st.tx_hold <= spi_ss_pkg::DATA_RST;
			st.rx_cnt  <= spi_ss_pkg::RXQ_EMPTY;
			st.val     <= spi_ss_pkg::PINS_LOW;
			st.oe_n    <= spi_ss_pkg::PINS_IN;
		end else begin
			st <= next_st;
		end
	end

	logic lost_now;
	assign lost_now = loss & ~master_wr;

	slave_reset_a: assert property (
		serial_unit_enable & ~st.master & st.s2.ss & ~loss |=> st.cnt == 3'h0)
		else $error("slave counter not cleared while deselected");

	ss_input_a: assert property (
		$past(serial_unit_enable) & ~st.master |-> st.oe_n.ss)
		else $error("select driven while slave");

	miso_drive_a: assert property (
		~st.oe_n.miso & $past(serial_unit_enable)
		|-> ~st.master & ~$past(st.s2.ss) & $past(pin_dir.miso))
		else $error("MISO driven without select low and user direction");

	slave_quiet_a: assert property (
		serial_unit_enable & ~st.master & st.s2.ss & ~master_wr
		|=> st.oe_n == 4'hF && st.cnt == 3'h0)
		else $error("deselected slave not passive");

	master_dir_a: assert property (
		$past(serial_unit_enable) & st.master |-> st.oe_n.ss == ~$past(pin_dir.ss))
		else $error("master select direction overridden");

	gpio_ss_a: assert property (
		serial_unit_enable & st.master & pin_dir.ss & ~master_wr |=> st.master)
		else $error("select output changed master mode");

	loss_clear_a: assert property (
		lost_now |=> ~st.master ##0 st.mst == spi_ss_pkg::M_IDLE)
		else $error("master bit not cleared on select low");

	loss_pins_a: assert property (
		lost_now & serial_unit_enable |=> st.oe_n.mosi & st.oe_n.sck)
		else $error("MOSI or SCK still driven after forced slave");

	loss_flag_a: assert property (
		lost_now |=> st.flag ##0 (irq == (transfer_irq_enable & global_irq_enable)))
		else $error("done flag or interrupt wrong after forced slave");

	stay_slave_a: assert property (
		~st.master & ~(master_wr & master_wdata) |=> ~st.master)
		else $error("master mode re-entered without a write");

	slave_hold_a: assert property (
		serial_unit_enable & ~st.master & st.s2.ss & ~master_wr & ~tx_take
		|=> st.shift == $past(st.tx_hold))
		else $error("deselected slave shifter moved");

	byte_flag_a: assert property (
		done |=> st.flag ##0 st.cnt == 3'h0 || st.mst == spi_ss_pkg::M_IDLE)
		else $error("done flag not set after a byte");

	sync_a: assert property (
		$past(rstn) & $past(rstn, 2) |-> st.s2 == $past(pin_in, 2))
		else $error("pin synchroniser depth wrong");

	rx_bound_a: assert property (
		st.rx_cnt <= spi_ss_pkg::RXQ_FULL)
		else $error("receive buffer count beyond two");

	tx_refuse_a: assert property (
		st.master & rx_full |-> ~tx_ready)
		else $error("master took a byte with a full receive buffer");

	overrun_drop_a: assert property (
		done & rx_full & ~pop |=> st.rx_cnt == spi_ss_pkg::RXQ_FULL)
		else $error("overrun byte entered the full buffer");

	slave_inputs_a: assert property (
		$past(serial_unit_enable) & ~st.master |-> st.oe_n.sck & st.oe_n.mosi)
		else $error("slave drives SCK or MOSI");

	slave_deaf_a: assert property (
		serial_unit_enable & ~st.master & st.s2.ss & ~master_wr |=> ~done)
		else $error("deselected slave finished a byte");

	flag_sticky_a: assert property (
		st.flag & ~flag_clr |=> st.flag)
		else $error("done flag dropped without a clear");

	flag_clear_a: assert property (
		st.flag & flag_clr & ~done & ~loss |=> ~st.flag)
		else $error("done flag not cleared");

	idle_sck_a: assert property (
		$past(serial_unit_enable) & st.master & st.mst == spi_ss_pkg::M_IDLE
		|-> ~pin_out.sck)
		else $error("master clock not low while idle");

	master_miso_a: assert property (
		$past(serial_unit_enable) & st.master |-> st.oe_n.miso)
		else $error("master drives MISO");

	master_byte_c: cover property (st.master & done);
	slave_byte_c:  cover property (~st.master & done);
	loss_c:        cover property (lost_now & st.mst != spi_ss_pkg::M_IDLE);
	rx_full_c:     cover property (rx_full & tx_valid & ~tx_ready);
	ss_abort_c:    cover property (~st.master & st.s2.ss & st.cnt != 3'h0);
endmodule : spi_ss_ctrl
`default_nettype wire

// [dv/spi_far_end.sv]
// Behavioural far-side SPI master that also sources MISO
`default_nettype none
module spi_far_end (
	input  wire logic       mosi_w,
	input  wire logic       miso_w,
	input  wire logic       sck_w,
	output logic            ss,
	output logic            sck,
	output logic            mosi,
	output logic            miso,
	output logic [7:0]      got,
	output logic [7:0]      mgot
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ss = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
		miso = 1'b0;
		got = 8'h00;
		mgot = 8'h00;
	end
	// MISO flips each rise so a stale level is never mistaken for data
	always @(posedge sck_w) begin
		got <= {got[6:0], mosi_w};
		mgot <= {mgot[6:0], miso_w};
		miso <= ~miso;
	end
	task automatic xfer(input logic [7:0] b, input int n, input int h, input bit sel);
		ss = !sel;
		#(h);
		for (int i = 7; i > 7 - n; i--) begin
			mosi = b[i];
			#(h);
			sck = 1'b1;
			#(h);
			sck = 1'b0;
		end
		mosi = ~mosi;
		#(h);
		ss = 1'b1;
		#(h);
	endtask : xfer
endmodule : spi_far_end
`default_nettype wire

// [dv/tb_spi_slave_select_control.sv]
// Testbench of the slave-select control block
`default_nettype none
module tb_spi_slave_select_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, ss_level, en, mwr, mwd, clr, tie, gie, tv, rr, kill_n;
	logic tr, rv, msb, flag, irq, fss, fsck, fmosi, fmiso;
	logic [7:0] td, rd, got, mgot, mrx;
	logic [7:0] e [3];
	spi_ss_pkg::pin_bus_s w, po, pe, dir;
	int err_count, n_tests, cyc;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	assign w.ss   = pe.ss ? (fss & kill_n) : po.ss;
	assign w.sck  = pe.sck ? fsck : po.sck;
	assign w.mosi = pe.mosi ? fmosi : po.mosi;
	assign w.miso = pe.miso ? fmiso : po.miso;
	spi_ss_ctrl dut (.clk(clk), .rstn(rstn), .pin_in(w), .pin_out(po), .pin_oe_n(pe),
		.pin_dir(dir), .ss_level(ss_level), .serial_unit_enable(en), .master_wr(mwr),
		.master_wdata(mwd), .master_select_bit(msb), .transfer_done_flag(flag),
		.flag_clr(clr), .transfer_irq_enable(tie), .global_irq_enable(gie), .irq(irq),
		.tx_valid(tv), .tx_data(td), .tx_ready(tr), .rx_valid(rv), .rx_data(rd),
		.rx_ready(rr));
	spi_far_end far (.mosi_w(w.mosi), .miso_w(w.miso), .sck_w(w.sck), .ss(fss),
		.sck(fsck), .mosi(fmosi), .miso(fmiso), .got(got), .mgot(mgot));
	task automatic chk(input logic c, input string m);
		n_tests++;
		if (!c) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cy
	task automatic pulse_tx(input logic [7:0] v);
		td = v;
		tv = 1'b1;
		@(posedge clk);
		while (tr !== 1'b1) @(posedge clk);
		#1;
		tv = 1'b0;
	endtask : pulse_tx
	task automatic mw(input logic v);
		mwr = 1'b1;
		mwd = v;
		cy(1);
		mwr = 1'b0;
		cy(1);
	endtask : mw
	task automatic fclr();
		clr = 1'b1;
		cy(1);
		clr = 1'b0;
	endtask : fclr
	task automatic pop(input logic [7:0] x);
		chk(rv === 1'b1 && rd === x, "rx head");
		rr = 1'b1;
		cy(1);
		rr = 1'b0;
		cy(1);
	endtask : pop
	task automatic finish_test();
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(32'hC0BA42C9));
		{rstn, en, mwr, mwd, clr, tie, gie, tv, rr} = '0;
		{ss_level, kill_n} = 2'h3;
		td = 8'h00;
		dir = 4'hF;
		repeat (12) @(posedge clk);
		#1 rstn = 1'b1;
		chk(pe === 4'hF && msb === 1'b0 && flag === 1'b0, "reset state");
		en = 1'b1;
		// Receiver stalls: third byte overruns and is dropped
		for (int k = 0; k < 3; k++) begin
			e[k] = (k == 0) ? 8'hFF : 8'($urandom);
			pulse_tx(8'($urandom));
			fork
				far.xfer(e[k], 8, (k == 2) ? 200 : 80, 1'b1);
				begin
					cy(30);
					chk(pe === 4'hE, "slave pins");
				end
			join
			chk(pe === 4'hF && flag === 1'b1, "passive or flag");
			chk(mgot === td, "miso byte");
			fclr();
		end
		pop(e[0]);
		pop(e[1]);
		far.xfer(8'h5A, 4, 80, 1'b1);
		chk(flag === 1'b0 && rv === 1'b0, "partial byte");
		far.xfer(8'hA5, 8, 80, 1'b1);
		pop(8'hA5);
		fclr();
		far.xfer(8'h3C, 8, 80, 1'b0);
		chk(rv === 1'b0 && flag === 1'b0, "ignored clocks");
		fclr();
		dir = 4'h6;
		mw(1'b1);
		chk(msb === 1'b1 && pe === 4'h9, "master pins");
		for (int k = 0; k < 2; k++) begin
			pulse_tx(8'($urandom));
			for (int i = 0; i < 80 && flag !== 1'b1; i++) cy(1);
			chk(flag === 1'b1 && got === td, "master byte");
			if (k == 0) mrx = mgot;
			fclr();
		end
		chk(tr === 1'b0, "full buffer refuses");
		chk(rv === 1'b1 && rd === mrx, "master rx head");
		rr = 1'b1;
		cy(2);
		rr = 1'b0;
		chk(rv === 1'b0 && tr === 1'b1, "buffer drained");
		dir = 4'hE;
		ss_level = 1'b0;
		cy(10);
		chk(msb === 1'b1 && pe.ss === 1'b0 && po.ss === 1'b0, "plain ss");
		// Select must read high again before it turns into an input
		ss_level = 1'b1;
		cy(4);
		dir = 4'h6;
		{tie, gie} = 2'h3;
		pulse_tx(8'($urandom));
		cy(20);
		kill_n = 1'b0;
		cy(6);
		chk(msb === 1'b0 && flag === 1'b1 && irq === 1'b1, "loss");
		chk(irq === 1'b1 && msb === 1'b0, "handler sees slave");
		chk(pe.sck === 1'b1 && pe.mosi === 1'b1, "released");
		tie = 1'b0;
		cy(1);
		chk(irq === 1'b0, "irq masked");
		kill_n = 1'b1;
		cy(20);
		chk(msb === 1'b0, "stays slave");
		mw(1'b1);
		chk(msb === 1'b1, "master again");
		finish_test();
	end
endmodule : tb_spi_slave_select_control
`default_nettype wire
